//--- rsml_pkg.sv
// package: constants and types for the reset strap mode latch
package rsml_pkg;
   // strap order on the strap pin vector
   localparam int N_STRAP   = 7;
   localparam int IDX_BOOT  = 0;
   localparam int IDX_IRQ   = 1;
   localparam int IDX_LINKW = 2;
   localparam int IDX_WPOL  = 3;
   localparam int IDX_TEST  = 4;

   // levels and pulls per pin, bit n is strap n
   localparam logic [6:0] STRAP_DEFAULT   = 7'h70;
   localparam logic [6:0] RST_PULLUP_MASK = 7'h70;
   localparam logic [6:0] RUN_PULLUP_MASK = 7'h09;

   // pin hand-back delay after the release edge
   localparam int CLK_PERIOD_PS = 25000;
   localparam int HANDOFF_NS    = 100;
   localparam int HANDOFF_CYC   = (HANDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // register map, byte addresses
   localparam logic [11:0] OFF_STATUS  = 12'h000;
   localparam logic [11:0] OFF_SYS_CFG = 12'h004;
   localparam logic [11:0] OFF_SDR_CFG = 12'h008;

   // status word fields
   localparam int ST_STRAP_POS    = 0;
   localparam int ST_RUN_POS      = 8;
   localparam int ST_SYS_LOCK_POS = 9;
   localparam int ST_SDR_LOCK_POS = 10;

   localparam logic [31:0] SYS_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] SDR_CFG_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PH_RESET, PH_HANDOFF, PH_RUN} rsml_phase_t;

   typedef struct packed {
      logic       boot_wait;
      logic       irq_enable;
      logic       irq_level;
      logic       link_width_4;
      logic       cfg_always_wr;
      logic [2:0] test;
   } rsml_mode_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } rsml_wreq_t;

   function automatic logic [31:0] rsml_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

//--- rsml_strap_pad.sv
// module: one strap pin, capture latch, pull control and hand-back
`timescale 1ns/10ps
module rsml_strap_pad import rsml_pkg::*; #(
   parameter logic DEF_LEVEL   = 1'b0,
   parameter logic RST_PULL_UP = 1'b0,
   parameter logic RUN_PULL_UP = 1'b0
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // sequencing
   input  wire logic capture,
   input  wire logic handoff,
   // pad
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe,
   output logic      pull_en,
   output logic      pull_up,
   // normal function side
   input  wire logic func_o,
   input  wire logic func_oe,
   output logic      strap_q
);
   logic strap_reg;
   logic out_reg;
   logic oe_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         strap_reg <= DEF_LEVEL;
      end else if (capture) begin
         strap_reg <= pin_i;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= 1'b0;
         oe_reg  <= 1'b0;
      end else begin
         out_reg <= func_o;
         oe_reg  <= func_oe;
      end
   end

   // gated by handoff directly so the pin lets go in the same cycle reset drops
   assign pin_oe  = handoff & oe_reg;
   assign pin_o   = out_reg;
   assign pull_en = !handoff || RUN_PULL_UP;
   assign pull_up = handoff ? RUN_PULL_UP : RST_PULL_UP;
   assign strap_q = strap_reg;
endmodule // rsml_strap_pad

//--- rsml_cfg_reg.sv
// module: configuration register with optional write-once lock
`timescale 1ns/10ps
module rsml_cfg_reg import rsml_pkg::*; #(
   parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clear,
   // policy and write
   input  wire logic        always_wr,
   input  wire logic        wr_en,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // state
   output logic [31:0]      q,
   output logic             written,
   output logic             blocked
);
   logic [31:0] q_reg;
   logic        written_reg;

   assign blocked = written_reg && !always_wr;

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         q_reg       <= RESET_VAL;
         written_reg <= 1'b0;
      end else if (wr_en && !blocked) begin
         q_reg       <= rsml_merge(q_reg, wdata, wstrb);
         written_reg <= 1'b1;
      end
   end

   assign q       = q_reg;
   assign written = written_reg;
endmodule // rsml_cfg_reg

//--- rsml_top.sv
// module: reset strap mode latch with AXI4-Lite register access
`timescale 1ns/10ps
module rsml_top import rsml_pkg::*; (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   // axi4-lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // external reset source
   input  wire logic        rst_in_n,
   // strap pads
   input  wire logic [6:0]  pin_i,
   output logic [6:0]       pin_o,
   output logic [6:0]       pin_oe,
   output logic [6:0]       pull_en,
   output logic [6:0]       pull_up,
   // normal pin functions
   input  wire logic [6:0]  func_o,
   input  wire logic [6:0]  func_oe,
   // captured modes and config
   output rsml_mode_t       mode,
   output logic             pins_released,
   output logic [31:0]      sys_cfg,
   output logic [31:0]      sdr_cfg
);
   function automatic logic word_hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction

   // release edge and hand-back sequencing
   rsml_phase_t phase_reg;
   rsml_phase_t phase_next;
   logic        rst_in_q_reg;
   logic [7:0]  ho_cnt_reg;
   logic        capture;
   logic        handoff;
   logic [6:0]  straps;

   // registers and bus state
   rsml_wreq_t  wreq_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        do_write;
   logic        wr_sys;
   logic        wr_sdr;
   logic        wr_ok;
   logic        rd_hit;
   logic [31:0] rd_word;
   logic [31:0] status_word;
   logic        sys_written;
   logic        sdr_written;
   logic        sys_blocked;
   logic        sdr_blocked;

   // a rise seen while reset was held high still counts, straps then stay at defaults otherwise
   assign capture = rst_in_n && !rst_in_q_reg;
   assign handoff = (phase_reg == PH_RUN) && rst_in_n;

   always_comb begin
      phase_next = phase_reg;
      unique case (phase_reg)
         PH_RESET: begin
            if (capture) begin
               phase_next = PH_HANDOFF;
            end
         end
         PH_HANDOFF: begin
            if (ho_cnt_reg == 8'(HANDOFF_CYC - 1)) begin
               phase_next = PH_RUN;
            end
         end
         PH_RUN: phase_next = PH_RUN;
      endcase
      if (!rst_in_n) begin
         phase_next = PH_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_reg    <= PH_RESET;
         rst_in_q_reg <= 1'b0;
         ho_cnt_reg   <= 8'h00;
      end else begin
         phase_reg    <= phase_next;
         rst_in_q_reg <= rst_in_n;
         ho_cnt_reg   <= (phase_reg == PH_HANDOFF) ? ho_cnt_reg + 8'h01 : 8'h00;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_STRAP; gi++) begin : g_pad
         rsml_strap_pad #(
            .DEF_LEVEL  (STRAP_DEFAULT[gi]),
            .RST_PULL_UP(RST_PULLUP_MASK[gi]),
            .RUN_PULL_UP(RUN_PULLUP_MASK[gi])
         ) u_pad (
            .clk    (clk),
            .rst    (rst),
            .capture(capture),
            .handoff(handoff),
            .pin_i  (pin_i[gi]),
            .pin_o  (pin_o[gi]),
            .pin_oe (pin_oe[gi]),
            .pull_en(pull_en[gi]),
            .pull_up(pull_up[gi]),
            .func_o (func_o[gi]),
            .func_oe(func_oe[gi]),
            .strap_q(straps[gi])
         );
      end
   endgenerate

   // modes come from the latched straps only
   assign mode.boot_wait     = straps[IDX_BOOT];
   assign mode.irq_enable    = straps[IDX_IRQ];
   assign mode.irq_level     = straps[IDX_IRQ];
   assign mode.link_width_4  = straps[IDX_LINKW];
   assign mode.cfg_always_wr = straps[IDX_WPOL];
   assign mode.test          = straps[IDX_TEST +: 3];
   assign pins_released      = handoff;

   // write path: address and data may arrive in either order
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign do_write      = aw_held_reg && w_held_reg;
   assign wr_sys        = do_write && word_hit(wreq_reg.addr, OFF_SYS_CFG);
   assign wr_sdr        = do_write && word_hit(wreq_reg.addr, OFF_SDR_CFG);
   assign wr_ok         = (wr_sys && !sys_blocked) || (wr_sdr && !sdr_blocked);

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         wreq_reg    <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg   <= 1'b1;
            wreq_reg.addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg    <= 1'b1;
            wreq_reg.data <= s_axi_wdata;
            wreq_reg.strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // device reset also reopens the one-time window
   rsml_cfg_reg #(.RESET_VAL(SYS_CFG_RESET)) u_sys_cfg (
      .clk      (clk),
      .rst      (rst),
      .clear    (!rst_in_n),
      .always_wr(mode.cfg_always_wr),
      .wr_en    (wr_sys),
      .wdata    (wreq_reg.data),
      .wstrb    (wreq_reg.strb),
      .q        (sys_cfg),
      .written  (sys_written),
      .blocked  (sys_blocked)
   );

   rsml_cfg_reg #(.RESET_VAL(SDR_CFG_RESET)) u_sdr_cfg (
      .clk      (clk),
      .rst      (rst),
      .clear    (!rst_in_n),
      .always_wr(mode.cfg_always_wr),
      .wr_en    (wr_sdr),
      .wdata    (wreq_reg.data),
      .wstrb    (wreq_reg.strb),
      .q        (sdr_cfg),
      .written  (sdr_written),
      .blocked  (sdr_blocked)
   );

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // read path
   always_comb begin
      status_word                  = 32'h0000_0000;
      status_word[ST_STRAP_POS +: 7] = straps;
      status_word[ST_RUN_POS]      = handoff;
      status_word[ST_SYS_LOCK_POS] = sys_blocked;
      status_word[ST_SDR_LOCK_POS] = sdr_blocked;
   end

   assign rd_hit  = word_hit(s_axi_araddr, OFF_STATUS) || word_hit(s_axi_araddr, OFF_SYS_CFG) ||
                    word_hit(s_axi_araddr, OFF_SDR_CFG);
   assign rd_word = word_hit(s_axi_araddr, OFF_STATUS)  ? status_word :
                    word_hit(s_axi_araddr, OFF_SYS_CFG) ? sys_cfg :
                    word_hit(s_axi_araddr, OFF_SDR_CFG) ? sdr_cfg : 32'h0000_0000;
   assign s_axi_arready = !rvalid_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   // checks
   localparam int AST_HO_DLY = HANDOFF_CYC + 1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_PINS_INPUT_IN_RESET:
      assert property (!rst_in_n |-> pin_oe == 7'h00)
      else $error("strap pin driven during reset");

   AST_CAPTURE_AT_RELEASE:
      assert property ((rst_in_n && !$past(rst_in_n)) |=> straps == $past(pin_i))
      else $error("straps not sampled at release edge");

   AST_LATCH_STABLE:
      assert property (!capture |=> $stable(straps) && $stable(mode))
      else $error("latched mode moved without a release edge");

   AST_HANDOFF_TIME:
      assert property (capture |=> !handoff ##(AST_HO_DLY - 1) (handoff || !rst_in_n))
      else $error("pins not handed back on time");

   AST_RESET_PULLS:
      assert property (!rst_in_n |-> pull_en == 7'h7F && pull_up == RST_PULLUP_MASK)
      else $error("reset pulls wrong");

   AST_BOOT_MODE:
      assert property (capture |=> mode.boot_wait == $past(pin_i[IDX_BOOT]))
      else $error("boot mode not from strap");

   AST_IRQ_MODE:
      assert property (capture |=> mode.irq_enable == $past(pin_i[IDX_IRQ]) && mode.irq_level == mode.irq_enable)
      else $error("interrupt mode not from strap");

   AST_LINK_WIDTH:
      assert property (capture |=> mode.link_width_4 == $past(pin_i[IDX_LINKW]))
      else $error("link width not from strap");

   AST_ALWAYS_WRITABLE:
      assert property ((wr_sys && mode.cfg_always_wr && wreq_reg.strb == 4'hF)
                       |=> sys_cfg == $past(wreq_reg.data) && s_axi_bresp == RESP_OKAY)
      else $error("always-writable write lost");

   AST_RUN_PULLS:
      assert property (handoff |-> pull_en == RUN_PULLUP_MASK && pull_up == RUN_PULLUP_MASK)
      else $error("run pulls wrong");

   AST_NO_RECAPTURE:
      assert property (handoff ##1 rst_in_n |-> $stable(straps))
      else $error("straps moved in normal operation");

   AST_ONE_TIME_WRITE:
      assert property ((wr_sdr && sdr_written && !mode.cfg_always_wr)
                       |=> $stable(sdr_cfg) && s_axi_bresp == RESP_SLVERR)
      else $error("second write not refused");

   COV_NONDEFAULT_BOOT: cover property (capture ##1 mode.boot_wait);
   COV_HANDBACK: cover property (capture ##AST_HO_DLY handoff);
   COV_REFUSED_WRITE: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   COV_WIDE_LINK: cover property (handoff && mode.link_width_4);
   COV_SYS_LOCKED: cover property (wr_sys && sys_written && !mode.cfg_always_wr);
endmodule // rsml_top

//--- rsml_board.sv
// board model: strap resistors, external reset source and pad resolution
`timescale 1ns/10ps
module rsml_board import rsml_pkg::*; (
   // clock
   input  wire logic       clk,
   // bench control
   input  wire logic       rst_req,
   input  wire logic [3:0] drive_mask,
   input  wire logic [3:0] drive_val,
   // reset source
   output logic            rst_in_n,
   // pads
   output logic [6:0]      pin_i,
   input  wire logic [6:0] pin_o,
   input  wire logic [6:0] pin_oe,
   input  wire logic [6:0] pull_en,
   input  wire logic [6:0] pull_up
);
   logic [6:0] last_lvl;
   logic [6:0] board_en;
   logic [6:0] board_val;

   // test straps are never overdriven, only the four mode straps
   assign board_en  = {3'h0, drive_mask};
   assign board_val = {3'h0, drive_val};

   // device drive wins, then the strong board resistor, then the weak pull
   always_comb begin
      for (int b = 0; b < 7; b++) begin
         if (pin_oe[b]) begin
            pin_i[b] = pin_o[b];
         end else if (board_en[b]) begin
            pin_i[b] = board_val[b];
         end else if (pull_en[b]) begin
            pin_i[b] = pull_up[b];
         end else begin
            pin_i[b] = ~last_lvl[b];
         end
      end
   end

   initial rst_in_n = 1'b0;
   always @(posedge clk) begin
      rst_in_n <= !rst_req;
      last_lvl <= pin_i;
   end
endmodule // rsml_board

//--- rsml_testbench.sv
// testbench: strap capture, pin hand-back and config write policy
`timescale 1ns/10ps
module testbench import rsml_pkg::*; ();
   logic        clk = 1'b0;
   logic        rst;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        rst_in_n, rst_req, pins_released;
   logic [3:0]  drive_mask, drive_val;
   logic [6:0]  pin_i, pin_o, pin_oe, pull_en, pull_up, func_o, func_oe;
   rsml_mode_t  mode;
   logic [31:0] sys_cfg, sdr_cfg;
   logic [31:0] seed = 32'h0000_8E1C;
   logic [1:0]  exp_b[$];
   logic [33:0] exp_r[$];
   int          fails = 0;
   int          tests_run = 0;
   int          cyc = 0;

   always #12.5 clk = ~clk;

   rsml_top i_dut (.clk(clk), .rst(rst),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .rst_in_n(rst_in_n), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe(pin_oe), .pull_en(pull_en), .pull_up(pull_up), .func_o(func_o), .func_oe(func_oe),
      .mode(mode), .pins_released(pins_released), .sys_cfg(sys_cfg), .sdr_cfg(sdr_cfg));

   rsml_board i_board (.clk(clk), .rst_req(rst_req), .drive_mask(drive_mask),
      .drive_val(drive_val), .rst_in_n(rst_in_n), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe(pin_oe), .pull_en(pull_en), .pull_up(pull_up));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // bready and rready stay high, so every response is taken at once
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                            input logic [1:0] er);
      logic pend;
      exp_b.push_back(er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      pend = 1'b1;
      while (pend) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) pend = 1'b0;
      end
   endtask

   task automatic axi_read(input logic [11:0] a, input logic [33:0] er);
      logic pend;
      exp_r.push_back(er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      pend = 1'b1;
      while (pend) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) pend = 1'b0;
      end
   endtask

   // response watcher takes the oldest note per response
   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         close_out();
      end
   end

   task automatic capture(input logic [3:0] fm, input logic [3:0] s);
      logic [6:0] es;
      rsml_mode_t em;
      es = {3'b111, s & fm};
      em = {es[0], es[1], es[1], es[2], es[3], es[6:4]};
      seed = xs(seed);
      drive_mask <= fm;
      drive_val  <= s;
      rst_req    <= 1'b1;
      func_o     <= seed[6:0];
      func_oe    <= seed[14:8];
      repeat (3) @(posedge clk);
      check(34'({pins_released, pin_oe}), 34'h0);
      check(34'({pull_en, pull_up}), 34'({7'h7F, 7'h70}));
      rst_req <= 1'b0;
      repeat (HANDOFF_CYC + 4) @(posedge clk);
      check(34'(mode), 34'(em));
      check(34'({pins_released, pin_oe, pin_o}), 34'({1'b1, func_oe, func_o}));
      check(34'({pull_en, pull_up}), 34'({7'h09, 7'h09}));
      // live pins now differ from what was captured
      drive_mask <= ~fm;
      drive_val  <= ~s;
      func_o     <= ~func_o;
      repeat (3) @(posedge clk);
      check(34'(mode), 34'(em));
      axi_read(OFF_STATUS, {RESP_OKAY, 32'h0000_0100 | 32'(es)});
   endtask

   task automatic cfg_test(input logic pol, input logic [6:0] es);
      logic [31:0] d1, d2, m, ex;
      logic [11:0] a;
      for (int k = 0; k < 2; k++) begin
         a = (k == 0) ? OFF_SYS_CFG : OFF_SDR_CFG;
         seed = xs(seed);
         d1 = seed;
         seed = xs(seed);
         d2 = seed;
         m = {{8{d2[3]}}, {8{d2[2]}}, {8{d2[1]}}, {8{d2[0]}}};
         ex = pol ? ((d1 & ~m) | (d2 & m)) : d1;
         axi_write(a, d1, 4'hF, RESP_OKAY);
         axi_write(a, d2, d2[3:0], pol ? RESP_OKAY : RESP_SLVERR);
         axi_read(a, {RESP_OKAY, ex});
         check(34'((k == 0) ? sys_cfg : sdr_cfg), 34'(ex));
      end
      // both registers now written once, so both lock unless always writable
      axi_read(OFF_STATUS, {RESP_OKAY, 32'h0000_0100 | 32'(es) | (pol ? 32'h0000_0000 : 32'h0000_0600)});
   endtask

   initial begin
      logic [3:0] fm, s;
      rst = 1'b1;
      rst_req = 1'b1;
      drive_mask = 4'h0;
      drive_val = 4'h0;
      func_o = 7'h00;
      func_oe = 7'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      axi_write(12'h00C, seed, 4'hF, RESP_SLVERR);
      axi_write(OFF_STATUS, seed, 4'hF, RESP_SLVERR);
      axi_read(12'h00C, {RESP_SLVERR, 32'h0000_0000});
      // every mode code, then undriven and random board straps
      for (int i = 0; i < 20; i++) begin
         seed = xs(seed);
         s  = (i < 16) ? 4'(i) : seed[3:0];
         fm = (i < 16) ? 4'hF : ((i == 16) ? 4'h0 : seed[7:4]);
         capture(fm, s);
         cfg_test(s[3] & fm[3], {3'b111, s & fm});
      end
      close_out();
   end
endmodule // testbench
